// ===== src/sst_defines.svh
// Opcode fields, function codes and field positions for the barrier, system-call and trap-if-equal decode
// How it works
// RL1: Barrier function 001111, any type field acts as zero
// RL2: Barrier orders only uncached and coherent accesses
// RL3: Earlier synchronizable accesses globally performed before later
// RL4: Load complete when destination register written
// RL5: Store complete when visible to all processors
// RL6: Instruction fetches are not held by barrier
// RL7: Load performed once later stores cannot change it
// RL8: Store performed once later loads return it
// RL9: Load global once performed for every storing agent
// RL10: Store global once observed by every loading agent
// RL11: Coherent I/O behaves as cached coherent processor
// RL12: Strongly ordered system: barrier is silent no-op
// RL13: Buffered uncached stores drain before later coherent accesses
// RL14: System-call instruction raises exception unconditionally
// RL15: System-call parameter field is never interpreted
// RL16: Trap-if-equal compares registers signed, traps on equal
// RL17: Trap code field never affects the trap
// RL18: Hold later accesses until memory acknowledges completion
`ifndef SST_DEFINES_SVH
`define SST_DEFINES_SVH

`define SST_INSTR_W        32
`define SST_DATA_W         64
`define SST_TAG_W          5

`define SST_OPC_MSB        31
`define SST_OPC_LSB        26
`define SST_FN_MSB         5
`define SST_FN_LSB         0
`define SST_RS_MSB         25
`define SST_RS_LSB         21
`define SST_RT_MSB         20
`define SST_RT_LSB         16

`define SST_OPC_MAJOR_A    6'h00
`define SST_FN_SYNC        6'h0f
`define SST_FN_SYSTEM_CALL_INSTR     6'h0c
`define SST_FN_TEQ         6'h34

`define SST_CNT_RST        4'h0

`endif

// ===== src/sst_pkg.sv
// Shared types of the barrier and trap decode block
package sst_pkg;

   typedef enum logic [1:0] {
      SST_UNCACHED,
      SST_COHERENT,
      SST_NONCOHERENT,
      SST_OTHER
   } sst_access_type;

   typedef enum logic [1:0] {
      SST_ST_IDLE,
      SST_ST_DRAIN,
      SST_ST_HANDSHAKE
   } sst_sync_state_type;

endpackage

// ===== src/sst_mem_if.sv
// Link between the core decode end and the memory-system end
`timescale 1ns/100ps
`default_nettype none
`include "sst_defines.svh"

interface sst_mem_if;
   logic                           req_valid;
   logic                           req_ready;
   logic                           req_store;
   sst_pkg::sst_access_type        req_type;
   logic [`SST_DATA_W-1:0]         req_data;
   logic [`SST_TAG_W-1:0]          req_tag;
   logic                           rsp_load_valid;
   logic [`SST_TAG_W-1:0]          rsp_load_tag;
   logic [`SST_DATA_W-1:0]         rsp_load_data;
   logic [1:0]                     rsp_store_cnt;
   logic                           sync_req;
   logic                           sync_ack;

   modport core (
      output req_valid, req_store, req_type, req_data, req_tag, sync_req,
      input  req_ready, rsp_load_valid, rsp_load_tag, rsp_load_data, rsp_store_cnt, sync_ack
   );

   modport mem (
      input  req_valid, req_store, req_type, req_data, req_tag, sync_req,
      output req_ready, rsp_load_valid, rsp_load_tag, rsp_load_data, rsp_store_cnt, sync_ack
   );
endinterface

`default_nettype wire

// ===== src/sst_mem.sv
// Memory-system end: one request stage, posted uncached stores, completion tracking, barrier acknowledge
`timescale 1ns/100ps
`default_nettype none
`include "sst_defines.svh"

module sst_mem #(
   parameter int PEND_W = 4
) (
   // Clock and reset
   input  wire logic                          CORE_CLK_I,
   input  wire logic                          RST_I,
   // Core link
   sst_mem_if.mem                             bus,
   // Fabric request
   output logic                               FAB_VALID_O,
   input  wire logic                          FAB_READY_I,
   output logic                               FAB_STORE_O,
   output sst_pkg::sst_access_type            FAB_TYPE_O,
   output logic [`SST_DATA_W-1:0]             FAB_DATA_O,
   output logic [`SST_TAG_W-1:0]              FAB_TAG_O,
   // Fabric completion
   input  wire logic                          FAB_DONE_I,
   input  wire logic                          FAB_DONE_STORE_I,
   input  wire sst_pkg::sst_access_type       FAB_DONE_TYPE_I,
   input  wire logic [`SST_TAG_W-1:0]         FAB_DONE_TAG_I,
   input  wire logic [`SST_DATA_W-1:0]        FAB_DONE_DATA_I
);

   logic                          stage_valid;
   logic                          stage_store;
   sst_pkg::sst_access_type       stage_type;
   logic [`SST_DATA_W-1:0]        stage_data;
   logic [`SST_TAG_W-1:0]         stage_tag;
   logic [PEND_W-1:0]             pend;
   logic [PEND_W-1:0]             next_pend;
   logic                          rsp_load_valid;
   logic [`SST_TAG_W-1:0]         rsp_load_tag;
   logic [`SST_DATA_W-1:0]        rsp_load_data;
   logic [1:0]                    rsp_store_cnt;

   wire pend_full   = &pend;
   wire fab_take    = stage_valid && !pend_full && FAB_READY_I;
   wire req_fire    = bus.req_valid && bus.req_ready;
   // Uncached stores are posted: the core sees them complete one cycle after acceptance
   wire posted_st   = req_fire && bus.req_store && (bus.req_type == sst_pkg::SST_UNCACHED);
   // A coherent store completes only when the fabric reports it globally visible
   wire visible_st  = FAB_DONE_I && FAB_DONE_STORE_I && (FAB_DONE_TYPE_I != sst_pkg::SST_UNCACHED); // see RL5 see RL8 see RL10
   wire load_done   = FAB_DONE_I && !FAB_DONE_STORE_I; // see RL7 see RL9

   assign bus.req_ready     = !stage_valid || fab_take;
   assign FAB_VALID_O       = stage_valid && !pend_full;
   assign FAB_STORE_O       = stage_store;
   assign FAB_TYPE_O        = stage_type;
   assign FAB_DATA_O        = stage_data;
   assign FAB_TAG_O         = stage_tag;
   assign next_pend         = pend + PEND_W'(fab_take) - PEND_W'(FAB_DONE_I);
   // Buffered uncached stores and all fabric traffic must be finished first
   assign bus.sync_ack      = bus.sync_req && !stage_valid && (pend == '0); // see RL13 see RL3
   assign bus.rsp_load_valid = rsp_load_valid;
   assign bus.rsp_load_tag  = rsp_load_tag;
   assign bus.rsp_load_data = rsp_load_data;
   assign bus.rsp_store_cnt = rsp_store_cnt;

   always_ff @(posedge CORE_CLK_I)
   begin
      if (RST_I)
      begin
         stage_valid <= 1'b0;
         stage_store <= 1'b0;
         stage_type  <= sst_pkg::SST_UNCACHED;
         stage_data  <= '0;
         stage_tag   <= '0;
      end
      else if (req_fire)
      begin
         stage_valid <= 1'b1;
         stage_store <= bus.req_store;
         stage_type  <= bus.req_type;
         stage_data  <= bus.req_data;
         stage_tag   <= bus.req_tag;
      end
      else if (fab_take)
      begin
         stage_valid <= 1'b0;
      end
   end

   always_ff @(posedge CORE_CLK_I)
   begin
      if (RST_I)
      begin
         pend           <= '0;
         rsp_load_valid <= 1'b0;
         rsp_load_tag   <= '0;
         rsp_load_data  <= '0;
         rsp_store_cnt  <= 2'h0;
      end
      else
      begin
         pend           <= next_pend;
         rsp_load_valid <= load_done;
         rsp_load_tag   <= FAB_DONE_TAG_I;
         rsp_load_data  <= FAB_DONE_DATA_I;
         rsp_store_cnt  <= {1'b0, posted_st} + {1'b0, visible_st};
      end
   end

endmodule

`default_nettype wire

// ===== src/sst_core.sv
// Core end: decode of barrier, system call and trap-if-equal, with barrier ordering of memory issue
`timescale 1ns/100ps
`default_nettype none
`include "sst_defines.svh"

module sst_core #(
   parameter int CNT_W        = 4,
   parameter bit STRONG_ORDER = 1'b0
) (
   // Clock and reset
   input  wire logic                          CORE_CLK_I,
   input  wire logic                          RST_I,
   // Instruction issue
   input  wire logic                          INSTR_VALID_I,
   input  wire logic [`SST_INSTR_W-1:0]       INSTR_I,
   input  wire logic [`SST_DATA_W-1:0]        RS_VALUE_I,
   input  wire logic [`SST_DATA_W-1:0]        RT_VALUE_I,
   output logic                               INSTR_READY_O,
   // Exceptions
   output logic                               SYSTEM_CALL_INSTR_EXC_O,
   output logic                               TRAP_EXC_O,
   // Memory operation issue
   input  wire logic                          MEM_VALID_I,
   input  wire logic                          MEM_STORE_I,
   input  wire sst_pkg::sst_access_type       MEM_TYPE_I,
   input  wire logic [`SST_DATA_W-1:0]        MEM_DATA_I,
   input  wire logic [`SST_TAG_W-1:0]         MEM_DEST_I,
   output logic                               MEM_READY_O,
   // Load write-back
   output logic                               LOAD_WE_O,
   output logic [`SST_TAG_W-1:0]              LOAD_DEST_O,
   output logic [`SST_DATA_W-1:0]             LOAD_DATA_O,
   // Status
   output logic                               SYNC_BUSY_O,
   // Memory link
   sst_mem_if.core                            bus
);

   // The 64-bit equality is split into slices so that the compare stays shallow
   localparam int SLICE_W   = 16;
   localparam int NUM_SLICE = `SST_DATA_W / SLICE_W;

   sst_pkg::sst_sync_state_type   state;
   sst_pkg::sst_sync_state_type   next_state;
   logic [CNT_W-1:0]              cnt;
   logic [CNT_W-1:0]              next_cnt;
   logic                          system_call_instr_exc;
   logic                          trap_exc;
   logic                          load_we;
   logic [`SST_TAG_W-1:0]         load_dest;
   logic [`SST_DATA_W-1:0]        load_data;
   logic                          next_system_call_instr_exc;
   logic                          next_trap_exc;
   logic [NUM_SLICE-1:0]          slice_equal;

   wire [5:0] opc      = INSTR_I[`SST_OPC_MSB:`SST_OPC_LSB];
   wire [5:0] fn       = INSTR_I[`SST_FN_MSB:`SST_FN_LSB];
   wire       major_a  = (opc == `SST_OPC_MAJOR_A);
   wire       instr_take = INSTR_VALID_I && INSTR_READY_O;
   // The type field is not looked at, so every value acts like zero
   wire       is_sync  = major_a && (fn == `SST_FN_SYNC); // see RL1
   // Parameter bits 25..6 are never decoded
   wire       is_system_call_instr_instr = major_a && (fn == `SST_FN_SYSTEM_CALL_INSTR); // see RL15
   // Code bits 15..6 are never decoded
   wire       is_trap_if_equal_instr = major_a && (fn == `SST_FN_TEQ); // see RL17
   // Equal two's complement words match bit for bit, so slices need no sign handling
   for (genvar g = 0; g < NUM_SLICE; g++)
   begin : g_slice
      assign slice_equal[g] = (RS_VALUE_I[g*SLICE_W +: SLICE_W] == RT_VALUE_I[g*SLICE_W +: SLICE_W]);
   end
   wire       regs_equal = &slice_equal; // see RL16
   wire       sync_take = instr_take && is_sync && !STRONG_ORDER; // see RL12
   wire       sync_type = (MEM_TYPE_I == sst_pkg::SST_UNCACHED) || (MEM_TYPE_I == sst_pkg::SST_COHERENT); // see RL2
   // Later synchronizable accesses wait for the barrier; other types pass
   wire       hold_sync = sync_type && ((state != sst_pkg::SST_ST_IDLE) || sync_take); // see RL3 see RL18
   wire       cnt_full  = &cnt;
   wire       drain_done = (cnt == '0);
   wire       issue_ok  = MEM_VALID_I && !cnt_full && !hold_sync;
   wire       mem_fire  = issue_ok && bus.req_ready;

   // Only further instructions stall; the fetch path is not part of this block
   assign INSTR_READY_O = (state == sst_pkg::SST_ST_IDLE); // see RL6
   assign MEM_READY_O   = !cnt_full && !hold_sync && bus.req_ready;
   assign bus.req_valid = issue_ok;
   assign bus.req_store = MEM_STORE_I;
   assign bus.req_type  = MEM_TYPE_I;
   assign bus.req_data  = MEM_DATA_I;
   assign bus.req_tag   = MEM_DEST_I;
   assign bus.sync_req  = (state == sst_pkg::SST_ST_HANDSHAKE); // see RL13
   assign SYNC_BUSY_O   = (state != sst_pkg::SST_ST_IDLE);
   assign SYSTEM_CALL_INSTR_EXC_O = system_call_instr_exc;
   assign TRAP_EXC_O    = trap_exc;
   assign LOAD_WE_O     = load_we;
   assign LOAD_DEST_O   = load_dest;
   assign LOAD_DATA_O   = load_data;

   assign next_system_call_instr_exc = instr_take && is_system_call_instr_instr; // see RL14
   assign next_trap_exc    = instr_take && is_trap_if_equal_instr && regs_equal; // see RL16

   // A load leaves the count on the cycle its register write is presented
   assign next_cnt = cnt + CNT_W'(mem_fire) - CNT_W'(load_we) - CNT_W'(bus.rsp_store_cnt); // see RL4 see RL5

   always_comb
   begin
      next_state = state;
      unique case (state)
         sst_pkg::SST_ST_IDLE:
         begin
            if (sync_take)
            begin
               next_state = sst_pkg::SST_ST_DRAIN;
            end
         end
         sst_pkg::SST_ST_DRAIN:
         begin
            if (drain_done)
            begin
               next_state = sst_pkg::SST_ST_HANDSHAKE; // see RL3
            end
         end
         sst_pkg::SST_ST_HANDSHAKE:
         begin
            if (bus.sync_ack)
            begin
               next_state = sst_pkg::SST_ST_IDLE; // see RL18
            end
         end
         default:
         begin
            next_state = sst_pkg::SST_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge CORE_CLK_I)
   begin
      if (RST_I)
      begin
         state <= sst_pkg::SST_ST_IDLE;
      end
      else
      begin
         state <= next_state;
      end
   end

   // Counts every outstanding access, not only ordered ones: simpler, and never weaker
   always_ff @(posedge CORE_CLK_I)
   begin
      if (RST_I)
      begin
         cnt <= CNT_W'(`SST_CNT_RST);
      end
      else
      begin
         cnt <= next_cnt;
      end
   end

   always_ff @(posedge CORE_CLK_I)
   begin
      if (RST_I)
      begin
         system_call_instr_exc <= 1'b0;
      end
      else
      begin
         system_call_instr_exc <= next_system_call_instr_exc;
      end
   end

   always_ff @(posedge CORE_CLK_I)
   begin
      if (RST_I)
      begin
         trap_exc <= 1'b0;
      end
      else
      begin
         trap_exc <= next_trap_exc;
      end
   end

   always_ff @(posedge CORE_CLK_I)
   begin
      if (RST_I)
      begin
         load_we <= 1'b0;
      end
      else
      begin
         load_we <= bus.rsp_load_valid; // see RL4
      end
   end

   // Write-back data only matters while the write strobe is high
   always_ff @(posedge CORE_CLK_I)
   begin
      if (RST_I)
      begin
         load_dest <= '0;
         load_data <= '0;
      end
      else
      begin
         load_dest <= bus.rsp_load_tag;
         load_data <= bus.rsp_load_data;
      end
   end

endmodule

`default_nettype wire

// ===== tb/sst_asserts.sv
// Barrier handshake and posted-store checks on the core to memory link
`timescale 1ns/100ps
`default_nettype none

module sst_asserts (
   // Clock and reset
   input  wire logic                    CORE_CLK_I,
   input  wire logic                    RST_I,
   // Link signals
   input  wire logic                    req_valid,
   input  wire logic                    req_ready,
   input  wire logic                    req_store,
   input  wire sst_pkg::sst_access_type req_type,
   input  wire logic [1:0]              rsp_store_cnt,
   input  wire logic                    sync_req,
   input  wire logic                    sync_ack
);
   default clocking @(posedge CORE_CLK_I); endclocking
   default disable iff (RST_I);
   wire logic fire = req_valid && req_ready;
   wire logic sync_kind = (req_type == sst_pkg::SST_UNCACHED) || (req_type == sst_pkg::SST_COHERENT);
   sequence s_handshake; sync_req && sync_ack; endsequence
   sequence s_sync_issue; fire && sync_kind; endsequence
   property p_ack_req; sync_ack |-> sync_req; endproperty
   a_ack_req: assert property (p_ack_req) else $error("ack without request");
   property p_req_hold; sync_req && !sync_ack |=> sync_req; endproperty
   a_req_hold: assert property (p_req_hold) else $error("request dropped early");
   property p_req_end; s_handshake |=> !sync_req; endproperty
   a_req_end: assert property (p_req_end) else $error("request held after ack");
   property p_no_issue; sync_req |-> not s_sync_issue; endproperty
   a_no_issue: assert property (p_no_issue) else $error("ordered access during barrier");
   property p_ack_empty; sync_ack |-> req_ready && rsp_store_cnt != 2'h3; endproperty
   a_ack_empty: assert property (p_ack_empty) else $error("ack with busy stage");
   property p_posted; fire && req_store && req_type == sst_pkg::SST_UNCACHED |=> rsp_store_cnt != 2'h0; endproperty
   a_posted: assert property (p_posted) else $error("uncached store not posted");
   property p_ack_bound; $rose(sync_req) |-> ##[0:400] sync_ack; endproperty
   a_ack_bound: assert property (p_ack_bound) else $error("barrier never acknowledged");
   property p_other_pass; sync_req && req_valid |-> !sync_kind; endproperty
   a_other_pass: assert property (p_other_pass) else $error("ordered access offered during barrier");
endmodule

`default_nettype wire

// ===== tb/sync_system_call_instr_trap_exec_bench.sv
// Self-checking bench for the decode end and the memory end joined by their link
`timescale 1ns/100ps
`default_nettype none
`include "sst_defines.svh"

module sync_system_call_instr_trap_exec_bench;
   logic clk, rst, iv, ir, sys_exc, trp_exc, mv, ms, mr, lwe, busy, fv, fr, fs, fd, fds;
   logic [31:0]             instr, r;
   logic [63:0]             a_val, b_val, md, fdat, ldat, fddat;
   logic [4:0]              mdst, ldst, ftag, fdtag;
   sst_pkg::sst_access_type mt, ft, fdt;
   int                      num_errors, check_count;
   logic [31:0]             lfsr;
   logic [1:0]              exc_q[$];
   logic [68:0]             load_q[$];
   logic [7:0]              fab_q[$];
   logic [66:0]             req_q[$];

   sst_mem_if sst_mem_if_inst ();
   sst_core #(.CNT_W(4), .STRONG_ORDER(1'b0)) sst_core_inst (.CORE_CLK_I(clk), .RST_I(rst),
      .INSTR_VALID_I(iv), .INSTR_I(instr), .RS_VALUE_I(a_val), .RT_VALUE_I(b_val), .INSTR_READY_O(ir),
      .SYSTEM_CALL_INSTR_EXC_O(sys_exc), .TRAP_EXC_O(trp_exc), .MEM_VALID_I(mv), .MEM_STORE_I(ms), .MEM_TYPE_I(mt),
      .MEM_DATA_I(md), .MEM_DEST_I(mdst), .MEM_READY_O(mr), .LOAD_WE_O(lwe), .LOAD_DEST_O(ldst),
      .LOAD_DATA_O(ldat), .SYNC_BUSY_O(busy), .bus(sst_mem_if_inst));
   sst_mem #(.PEND_W(4)) sst_mem_inst (.CORE_CLK_I(clk), .RST_I(rst), .bus(sst_mem_if_inst),
      .FAB_VALID_O(fv), .FAB_READY_I(fr), .FAB_STORE_O(fs), .FAB_TYPE_O(ft), .FAB_DATA_O(fdat),
      .FAB_TAG_O(ftag), .FAB_DONE_I(fd), .FAB_DONE_STORE_I(fds), .FAB_DONE_TYPE_I(fdt),
      .FAB_DONE_TAG_I(fdtag), .FAB_DONE_DATA_I(fddat));
   sst_asserts sst_asserts_inst (.CORE_CLK_I(clk), .RST_I(rst), .req_valid(sst_mem_if_inst.req_valid),
      .req_ready(sst_mem_if_inst.req_ready), .req_store(sst_mem_if_inst.req_store),
      .req_type(sst_mem_if_inst.req_type), .rsp_store_cnt(sst_mem_if_inst.rsp_store_cnt),
      .sync_req(sst_mem_if_inst.sync_req), .sync_ack(sst_mem_if_inst.sync_ack));

   function automatic logic [31:0] rnd();
      lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h0040_0007 : 32'h0000_0000);
      return lfsr;
   endfunction

   task automatic report(input logic [68:0] e, input logic [68:0] g);
      check_count++;
      if (g !== e)
      begin
         num_errors++;
         $display("CHECK FAILED at %0t: expected %h got %h", $time, e, g);
      end
   endtask
   task automatic check_exc(input logic [1:0] e, input logic [1:0] g); report({67'h0, e}, {67'h0, g}); endtask
   task automatic check_load(input logic [68:0] e, input logic [68:0] g); report(e, g); endtask
   task automatic check_req(input logic [66:0] e, input logic [66:0] g); report({2'h0, e}, {2'h0, g}); endtask

   task automatic wrap_up();
      $display("Checks %0d, mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Presents a word, notes the expected exception, returns at the taking edge
   task automatic issue(input logic [31:0] w, input logic [63:0] a, input logic [63:0] b);
      int n;
      n = 0;
      @(negedge clk);
      {instr, a_val, b_val, iv} = {w, a, b, 1'b1};
      while (ir !== 1'b1 && n < 500)
      begin
         n++;
         @(negedge clk);
      end
      if (w[31:26] == `SST_OPC_MAJOR_A && w[5:0] == `SST_FN_SYSTEM_CALL_INSTR)
         exc_q.push_back(2'b10);
      if (w[31:26] == `SST_OPC_MAJOR_A && w[5:0] == `SST_FN_TEQ && a == b)
         exc_q.push_back(2'b01);
      @(posedge clk);
   endtask

   task automatic mem_op(input logic [31:0] x);
      int n;
      n = 0;
      @(negedge clk);
      {mv, ms, mdst, md} = {1'b1, x[2], x[7:3], x, x};
      mt = sst_pkg::sst_access_type'(x[1:0]);
      // Ready depends on fabric and barrier inputs that also change on this edge
      #1;
      while (mr !== 1'b1 && n < 500)
      begin
         n++;
         @(negedge clk);
         #1;
      end
      req_q.push_back({x[2], x[1:0], x, x});
      if (!x[2])
         load_q.push_back({x[7:3], 32'h5a5a_c3c3, 27'h0, x[7:3]});
      @(posedge clk);
   endtask

   always @(negedge clk)
   begin
      if (sys_exc || trp_exc)
         check_exc(exc_q.size() ? exc_q.pop_front() : 2'b00, {sys_exc, trp_exc});
      if (lwe)
         check_load(load_q.size() ? load_q.pop_front() : 69'h0, {ldst, ldat});
   end

   // Fabric: random stalls, completions in order echoing store and type
   always @(posedge clk)
      if (!rst && fv && fr)
      begin
         fab_q.push_back({fs, ft, ftag});
         check_req(req_q.size() ? req_q.pop_front() : 67'h0, {fs, ft, fdat});
      end
   always @(negedge clk)
   begin
      r = rnd();
      fr = r[0] | r[1];
      fd = fab_q.size() != 0 && r[2];
      if (fd)
      begin
         {fds, fdtag} = {fab_q[0][7], fab_q[0][4:0]};
         fdt = sst_pkg::sst_access_type'(fab_q[0][6:5]);
         fddat = {32'h5a5a_c3c3, 27'h0, fab_q[0][4:0]};
         fab_q.delete(0);
      end
   end

   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   initial
   begin
      #200000;
      num_errors++;
      wrap_up();
   end

   initial
   begin
      rst = 1'b1;
      {iv, mv, ms, fr, fd, fds, instr, a_val, b_val, md, mdst, fdtag, fddat} = '0;
      {mt, fdt} = {sst_pkg::SST_UNCACHED, sst_pkg::SST_UNCACHED};
      lfsr = 32'h0000_dfda;
      repeat (16) @(posedge clk);
      @(negedge clk) rst = 1'b0;
      for (int i = 0; i < 32; i++)
      begin
         r = rnd();
         issue({6'h00, r[19:0], `SST_FN_SYSTEM_CALL_INSTR}, {r, r}, 64'h0);
         issue({r[31:26] | 6'h01, r[25:6], `SST_FN_SYSTEM_CALL_INSTR}, 64'h0, 64'h0);
         issue({6'h00, r[9:0], r[29:20], `SST_FN_TEQ}, {r, r}, {r, r} ^ {i[0], 62'h0, i[1]});
         issue({6'h00, 15'h0000, i[4:0], `SST_FN_SYNC}, {r, r}, {r, r});
         @(negedge clk) iv = 1'b0;
         check_exc(2'b01, {1'b0, busy});
      end
      fork
         begin
            for (int j = 0; j < 60; j++)
               mem_op(rnd());
            @(negedge clk) mv = 1'b0;
         end
         for (int k = 0; k < 12; k++)
         begin
            repeat (4) @(negedge clk);
            issue({6'h00, 15'h0000, k[4:0], `SST_FN_SYNC}, 64'h0, 64'h0);
            @(negedge clk) iv = 1'b0;
         end
      join
      repeat (300) @(negedge clk);
      check_exc(2'b00, {1'b0, busy});
      check_load(69'h0, 69'(exc_q.size() + load_q.size() + req_q.size()));
      wrap_up();
   end
endmodule

`default_nettype wire
